//--- common/bfp_pkg.sv
// Constants, types and register map of the breaker failure pick-up block.
package bfp_pkg;
    // Register byte offsets on the Wishbone slave.
    localparam logic [7:0] OFS_MODE     = 8'h00;
    localparam logic [7:0] OFS_PHASE    = 8'h04;
    localparam logic [7:0] OFS_RESID    = 8'h08;
    localparam logic [7:0] OFS_RT_DLY   = 8'h0C;
    localparam logic [7:0] OFS_FL_DLY   = 8'h10;
    localparam logic [7:0] OFS_SRC      = 8'h14;
    localparam logic [7:0] OFS_SIG_MASK = 8'h18;
    localparam logic [7:0] OFS_DO_MASK  = 8'h1C;
    localparam logic [7:0] OFS_FORCE    = 8'h20;
    localparam logic [7:0] OFS_STATUS   = 8'h24;

    // Field positions.
    localparam int MODE_LSB      = 0;
    localparam int MODE_MSB      = 3;
    localparam int RT_EN_BIT     = 4;
    localparam int FORCE_EN_BIT  = 0;
    localparam int FORCE_LSB     = 1;
    localparam int FORCE_MSB     = 3;
    localparam int ST_LSB        = 0;
    localparam int ST_MSB        = 2;
    localparam int ST_RT_BIT     = 3;
    localparam int ST_FAIL_BIT   = 4;
    localparam int ST_PH_BIT     = 5;
    localparam int ST_RES_BIT    = 6;
    localparam int ST_PICK_BIT   = 7;

    // Widths.
    localparam int MAG_W = 20;  // Magnitudes and levels in 0.001 x In units.
    localparam int PH_W  = 12;  // Phase level in 0.01 x In units.
    localparam int DLY_W = 20;  // Delays in 5 ms steps.

    // Fixed release hysteresis of 97 percent.
    localparam int HYST_NUM    = 97;
    localparam int HYST_DEN    = 100;
    localparam int PHASE_SCALE = 10;   // 0.01 x In steps to 0.001 x In steps.

    // Processing cycle timing.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int CYCLE_TIME_US = 5000;
    localparam int CYCLE_CYCLES  = (CYCLE_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);

    // Delay defaults in milliseconds and their step count.
    localparam int STEP_MS      = 5;
    localparam int RT_DLY_MS    = 100;
    localparam int FL_DLY_MS    = 200;
    localparam logic [DLY_W-1:0] RT_DLY_RST = DLY_W'(RT_DLY_MS / STEP_MS);
    localparam logic [DLY_W-1:0] FL_DLY_RST = DLY_W'(FL_DLY_MS / STEP_MS);

    // Level defaults: 0.20 x In and 1.200 x In.
    localparam logic [PH_W-1:0]  PHASE_RST = 12'h014;
    localparam logic [MAG_W-1:0] RESID_RST = 20'h004B0;

    // Residual source selector.
    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_ONE  = 2'h1,
        SRC_TWO  = 2'h2,
        SRC_CALC = 2'h3
    } bfp_src_e;

    // Operating modes.
    typedef enum logic [3:0] {
        MD_CUR           = 4'h0,
        MD_DO            = 4'h1,
        MD_SIG           = 4'h2,
        MD_CUR_AND_DO    = 4'h3,
        MD_CUR_OR_DO     = 4'h4,
        MD_CUR_OR_SIG    = 4'h5,
        MD_CUR_OR_SIG_DO = 4'h6,
        MD_SIG_OR_DO     = 4'h7,
        MD_CUR_AND_SIG   = 4'h8,
        MD_CUR_SIG_DO    = 4'h9,
        MD_SIG_AND_DO    = 4'hA
    } bfp_mode_e;

    // Function status.
    typedef enum logic [2:0] {
        ST_NORMAL  = 3'h0,
        ST_START   = 3'h1,
        ST_RETRIP  = 3'h2,
        ST_FAILURE = 3'h3,
        ST_BLOCKED = 3'h4
    } bfp_status_e;
endpackage

//--- common/bfp_tmr_if.sv
// Interface joining the status logic to one delay timer.
`timescale 1ns/100ps
interface bfp_tmr_if #(
    parameter int DLY_W = 20
);
    logic             tick;
    logic             run;
    logic [DLY_W-1:0] delay;
    logic             done;

    modport ctl (output tick, output run, output delay, input done);
    modport tmr (input tick, input run, input delay, output done);
endinterface

//--- hdl/bfp_level_cmp.sv
// Threshold comparator with fixed release hysteresis, updated once per cycle tick.
`timescale 1ns/100ps
module bfp_level_cmp #(
    parameter int MAG_W = 20
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             tick_i,
    input  wire logic             enable_i,
    input  wire logic [MAG_W-1:0] mag_i,
    input  wire logic [MAG_W-1:0] level_i,
    output logic                  pick_o
);
    localparam int PW = MAG_W + 8;
    logic          pick_q;
    logic          pick_d;
    logic [PW-1:0] mag_x;
    logic [PW-1:0] lvl_x;

    // Release only below 97 percent of the level; compare scaled to avoid a divider.
    always_comb begin
        mag_x  = PW'(mag_i) * PW'(bfp_pkg::HYST_DEN);
        lvl_x  = PW'(level_i) * PW'(bfp_pkg::HYST_NUM);
        pick_d = pick_q;
        if (!enable_i) begin
            pick_d = 1'b0;
        end else if (tick_i) begin
            if (pick_q) begin
                pick_d = !(mag_x < lvl_x);
            end else begin
                pick_d = mag_i > level_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pick_q <= 1'b0;
        end else begin
            pick_q <= pick_d;
        end
    end

    assign pick_o = pick_q;
endmodule // bfp_level_cmp

//--- hdl/bfp_delay_timer.sv
// Definite delay timer counting processing cycles while its start condition holds.
`timescale 1ns/100ps
module bfp_delay_timer #(
    parameter int DLY_W = 20
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    bfp_tmr_if.tmr    tmr
);
    logic [DLY_W-1:0] cnt_q;
    logic [DLY_W-1:0] cnt_d;

    // Count saturates at the delay; a dropped condition restarts from zero.
    always_comb begin
        cnt_d = cnt_q;
        if (!tmr.run) begin
            cnt_d = '0;
        end else if (tmr.tick && (cnt_q < tmr.delay)) begin
            cnt_d = cnt_q + DLY_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // A delay shortened below the count while running fires at once.
    assign tmr.done = tmr.run && (cnt_q >= tmr.delay);
endmodule // bfp_delay_timer

//--- hdl/bfp_top.sv
// Breaker failure pick-up, criteria selection, timers and Wishbone registers.
`timescale 1ns/100ps
module bfp_top #(
    parameter int SIG_W        = 16,
    parameter int DO_W         = 8,
    parameter int CYCLE_CYCLES = bfp_pkg::CYCLE_CYCLES
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      rst_i,
    // Wishbone classic slave.
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [7:0]                wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // Magnitudes in 0.001 x In units.
    input  wire logic [bfp_pkg::MAG_W-1:0] phase_l1_i,
    input  wire logic [bfp_pkg::MAG_W-1:0] phase_l2_i,
    input  wire logic [bfp_pkg::MAG_W-1:0] phase_l3_i,
    input  wire logic [bfp_pkg::MAG_W-1:0] residual_input_one_i,
    input  wire logic [bfp_pkg::MAG_W-1:0] residual_input_two_i,
    input  wire logic [bfp_pkg::MAG_W-1:0] computed_residual_i,
    // Trip events, relay controls and blocking.
    input  wire logic [SIG_W-1:0]          trip_sig_i,
    input  wire logic [DO_W-1:0]           relay_ctrl_i,
    input  wire logic                      block_i,
    input  wire logic                      force_allow_i,
    // Function outputs.
    output logic                           start_o,
    output logic                           retrip_o,
    output logic                           breaker_failure_output_o,
    output logic                           blocked_o,
    output logic [2:0]                     status_o,
    output logic                           cycle_tick_o
);
    localparam int MAG_W = bfp_pkg::MAG_W;
    localparam int DLY_W = bfp_pkg::DLY_W;
    localparam int TW    = $clog2(CYCLE_CYCLES);

    // Combine the three criteria as the operating mode asks.
    function automatic logic mode_pick(input logic [3:0] m, input logic c,
                                       input logic s, input logic d);
        logic r;
        r = 1'b0;
        case (m)
            bfp_pkg::MD_CUR:           r = c;
            bfp_pkg::MD_DO:            r = d;
            bfp_pkg::MD_SIG:           r = s;
            bfp_pkg::MD_CUR_AND_DO:    r = c & d;
            bfp_pkg::MD_CUR_OR_DO:     r = c | d;
            bfp_pkg::MD_CUR_OR_SIG:    r = c | s;
            bfp_pkg::MD_CUR_OR_SIG_DO: r = c | s | d;
            bfp_pkg::MD_SIG_OR_DO:     r = s | d;
            bfp_pkg::MD_CUR_AND_SIG:   r = c & s;
            bfp_pkg::MD_CUR_SIG_DO:    r = c & s & d;
            bfp_pkg::MD_SIG_AND_DO:    r = s & d;
            default:                   r = 1'b0;
        endcase
        return r;
    endfunction

    // Merge a write into a register under the byte enables.
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Software registers.
    logic [3:0]       mode_q,   mode_d;
    logic             rt_en_q,  rt_en_d;
    logic [bfp_pkg::PH_W-1:0] phase_q, phase_d;
    logic [MAG_W-1:0] resid_q,  resid_d;
    logic [DLY_W-1:0] rt_dly_q, rt_dly_d;
    logic [DLY_W-1:0] fl_dly_q, fl_dly_d;
    logic [1:0]       src_q,    src_d;
    logic [SIG_W-1:0] sigm_q,   sigm_d;
    logic [DO_W-1:0]  dom_q,    dom_d;
    logic             fen_q,    fen_d;
    logic [2:0]       fst_q,    fst_d;
    logic             ack_q,    ack_d;
    logic [31:0]      rdat_q,   rdat_d;
    logic [31:0]      wr_old;
    logic [31:0]      wr_new;
    logic             wr_en;

    // Processing cycle and status state.
    logic [TW-1:0]    tcnt_q,   tcnt_d;
    logic             tick;
    bfp_pkg::bfp_status_e st_q, st_d;
    logic             rt_q,     rt_d;
    logic             fl_q,     fl_d;

    // Pick-up terms.
    logic             ph1, ph2, ph3, res_pick;
    logic [MAG_W-1:0] res_mag;
    logic [MAG_W-1:0] ph_level;
    logic             cur_pick, sig_pick, do_pick, pick;
    logic             rt_done, fl_done;
    logic [2:0]       eff_st;

    bfp_tmr_if #(.DLY_W(DLY_W)) rt_if ();
    bfp_tmr_if #(.DLY_W(DLY_W)) fl_if ();

    // Processing cycle tick, one clock every 5 ms.
    always_comb begin
        tick   = (tcnt_q == TW'(CYCLE_CYCLES - 1));
        tcnt_d = tick ? '0 : tcnt_q + TW'(1);
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            tcnt_q <= '0;
        end else begin
            tcnt_q <= tcnt_d;
        end
    end

    // Residual source and phase level scaling into common units.
    always_comb begin
        ph_level = MAG_W'(phase_q) * MAG_W'(bfp_pkg::PHASE_SCALE);
        case (src_q)
            bfp_pkg::SRC_ONE:  res_mag = residual_input_one_i;
            bfp_pkg::SRC_TWO:  res_mag = residual_input_two_i;
            bfp_pkg::SRC_CALC: res_mag = computed_residual_i;
            default:           res_mag = '0;
        endcase
    end

    bfp_level_cmp #(.MAG_W(MAG_W)) u_cmp_l1 (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .enable_i  (1'b1),
        .mag_i     (phase_l1_i),
        .level_i   (ph_level),
        .pick_o    (ph1)
    );
    bfp_level_cmp #(.MAG_W(MAG_W)) u_cmp_l2 (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .enable_i  (1'b1),
        .mag_i     (phase_l2_i),
        .level_i   (ph_level),
        .pick_o    (ph2)
    );
    bfp_level_cmp #(.MAG_W(MAG_W)) u_cmp_l3 (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .enable_i  (1'b1),
        .mag_i     (phase_l3_i),
        .level_i   (ph_level),
        .pick_o    (ph3)
    );
    // With no residual source chosen the residual element stays cleared.
    bfp_level_cmp #(.MAG_W(MAG_W)) u_cmp_res (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .enable_i  (src_q != bfp_pkg::SRC_NONE),
        .mag_i     (res_mag),
        .level_i   (resid_q),
        .pick_o    (res_pick)
    );

    // Criteria: masks only count when the mode includes them.
    always_comb begin
        cur_pick = ph1 | ph2 | ph3 | res_pick;
        sig_pick = |(trip_sig_i & sigm_q);
        do_pick  = |(relay_ctrl_i & dom_q);
        pick     = mode_pick(mode_q, cur_pick, sig_pick, do_pick);
    end

    // Both timers share one start; blocking holds them cleared.
    assign rt_if.tick  = tick;
    assign rt_if.run   = pick && !block_i && (st_q != bfp_pkg::ST_BLOCKED);
    assign rt_if.delay = rt_dly_q;
    assign fl_if.tick  = tick;
    assign fl_if.run   = rt_if.run;
    assign fl_if.delay = fl_dly_q;
    assign rt_done     = rt_if.done;
    assign fl_done     = fl_if.done;

    bfp_delay_timer #(.DLY_W(DLY_W)) u_rt_tmr (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tmr       (rt_if.tmr)
    );
    bfp_delay_timer #(.DLY_W(DLY_W)) u_fl_tmr (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .tmr       (fl_if.tmr)
    );

    // Status is resolved once per processing cycle.
    always_comb begin
        st_d = st_q;
        rt_d = rt_q;
        fl_d = fl_q;
        if (tick) begin
            rt_d = 1'b0;
            fl_d = 1'b0;
            if (!pick) begin
                st_d = bfp_pkg::ST_NORMAL;
            end else if (block_i || st_q == bfp_pkg::ST_BLOCKED) begin
                st_d = bfp_pkg::ST_BLOCKED;
            end else begin
                st_d = bfp_pkg::ST_START;
                rt_d = rt_done && rt_en_q;
                fl_d = fl_done;
                if (fl_done) begin
                    st_d = bfp_pkg::ST_FAILURE;
                end else if (rt_done && rt_en_q) begin
                    st_d = bfp_pkg::ST_RETRIP;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_q <= bfp_pkg::ST_NORMAL;
            rt_q <= 1'b0;
            fl_q <= 1'b0;
        end else begin
            st_q <= st_d;
            rt_q <= rt_d;
            fl_q <= fl_d;
        end
    end

    // Forcing overrides what the outputs show, not the supervision itself.
    always_comb begin
        eff_st = (fen_q && force_allow_i) ? fst_q : st_q;
        start_o                  = (eff_st == bfp_pkg::ST_START) ||
                                   (eff_st == bfp_pkg::ST_RETRIP) ||
                                   (eff_st == bfp_pkg::ST_FAILURE);
        retrip_o                 = (fen_q && force_allow_i) ?
                                   (eff_st == bfp_pkg::ST_RETRIP) && rt_en_q : rt_q;
        breaker_failure_output_o = (fen_q && force_allow_i) ?
                                   (eff_st == bfp_pkg::ST_FAILURE) : fl_q;
        blocked_o                = (eff_st == bfp_pkg::ST_BLOCKED);
        status_o                 = eff_st;
        cycle_tick_o             = tick;
    end

    // Wishbone slave: registered ack one cycle after the strobe, dropped the next.
    always_comb begin
        mode_d   = mode_q;
        rt_en_d  = rt_en_q;
        phase_d  = phase_q;
        resid_d  = resid_q;
        rt_dly_d = rt_dly_q;
        fl_dly_d = fl_dly_q;
        src_d    = src_q;
        sigm_d   = sigm_q;
        dom_d    = dom_q;
        fen_d    = fen_q;
        fst_d    = fst_q;
        rdat_d   = rdat_q;
        wr_old   = '0;
        ack_d    = wb_cyc_i && wb_stb_i && !ack_q;
        wr_en    = ack_d && wb_we_i;
        case (wb_adr_i)
            bfp_pkg::OFS_MODE: begin
                wr_old[bfp_pkg::MODE_MSB:bfp_pkg::MODE_LSB] = mode_q;
                wr_old[bfp_pkg::RT_EN_BIT] = rt_en_q;
            end
            bfp_pkg::OFS_PHASE:    wr_old = 32'(phase_q);
            bfp_pkg::OFS_RESID:    wr_old = 32'(resid_q);
            bfp_pkg::OFS_RT_DLY:   wr_old = 32'(rt_dly_q);
            bfp_pkg::OFS_FL_DLY:   wr_old = 32'(fl_dly_q);
            bfp_pkg::OFS_SRC:      wr_old = 32'(src_q);
            bfp_pkg::OFS_SIG_MASK: wr_old = 32'(sigm_q);
            bfp_pkg::OFS_DO_MASK:  wr_old = 32'(dom_q);
            bfp_pkg::OFS_FORCE: begin
                wr_old[bfp_pkg::FORCE_EN_BIT] = fen_q;
                wr_old[bfp_pkg::FORCE_MSB:bfp_pkg::FORCE_LSB] = fst_q;
            end
            bfp_pkg::OFS_STATUS: begin
                wr_old[bfp_pkg::ST_MSB:bfp_pkg::ST_LSB] = eff_st;
                wr_old[bfp_pkg::ST_RT_BIT]   = retrip_o;
                wr_old[bfp_pkg::ST_FAIL_BIT] = breaker_failure_output_o;
                wr_old[bfp_pkg::ST_PH_BIT]   = ph1 | ph2 | ph3;
                wr_old[bfp_pkg::ST_RES_BIT]  = res_pick;
                wr_old[bfp_pkg::ST_PICK_BIT] = pick;
            end
            default: wr_old = '0;
        endcase
        wr_new = wmerge(wr_old, wb_dat_i, wb_sel_i);
        if (ack_d && !wb_we_i) begin
            rdat_d = wr_old;
        end
        // Every writable register may change while running, source, masks and forcing included.
        if (wr_en) begin
            case (wb_adr_i)
                bfp_pkg::OFS_MODE: begin
                    mode_d  = wr_new[bfp_pkg::MODE_MSB:bfp_pkg::MODE_LSB];
                    rt_en_d = wr_new[bfp_pkg::RT_EN_BIT];
                end
                bfp_pkg::OFS_PHASE:    phase_d  = wr_new[bfp_pkg::PH_W-1:0];
                bfp_pkg::OFS_RESID:    resid_d  = wr_new[MAG_W-1:0];
                bfp_pkg::OFS_RT_DLY:   rt_dly_d = wr_new[DLY_W-1:0];
                bfp_pkg::OFS_FL_DLY:   fl_dly_d = wr_new[DLY_W-1:0];
                bfp_pkg::OFS_SRC:      src_d    = wr_new[1:0];
                bfp_pkg::OFS_SIG_MASK: sigm_d   = wr_new[SIG_W-1:0];
                bfp_pkg::OFS_DO_MASK:  dom_d    = wr_new[DO_W-1:0];
                bfp_pkg::OFS_FORCE: begin
                    fen_d = wr_new[bfp_pkg::FORCE_EN_BIT];
                    fst_d = wr_new[bfp_pkg::FORCE_MSB:bfp_pkg::FORCE_LSB];
                end
                default: fen_d = fen_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            mode_q   <= bfp_pkg::MD_CUR;
            rt_en_q  <= 1'b1;
            phase_q  <= bfp_pkg::PHASE_RST;
            resid_q  <= bfp_pkg::RESID_RST;
            rt_dly_q <= bfp_pkg::RT_DLY_RST;
            fl_dly_q <= bfp_pkg::FL_DLY_RST;
            src_q    <= bfp_pkg::SRC_NONE;
            sigm_q   <= '0;
            dom_q    <= '0;
            fen_q    <= 1'b0;
            fst_q    <= bfp_pkg::ST_NORMAL;
            ack_q    <= 1'b0;
            rdat_q   <= '0;
        end else begin
            mode_q   <= mode_d;
            rt_en_q  <= rt_en_d;
            phase_q  <= phase_d;
            resid_q  <= resid_d;
            rt_dly_q <= rt_dly_d;
            fl_dly_q <= fl_dly_d;
            src_q    <= src_d;
            sigm_q   <= sigm_d;
            dom_q    <= dom_d;
            fen_q    <= fen_d;
            fst_q    <= fst_d;
            ack_q    <= ack_d;
            rdat_q   <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
endmodule // bfp_top

//--- sim/bfp_front_model.sv
// Behavioural current front end feeding the breaker failure pick-up block.
`timescale 1ns/100ps
module bfp_front_model (
    input  wire logic                      clk_sys_i,
    input  wire logic                      tick_i,
    input  wire logic [bfp_pkg::MAG_W-1:0] set_i [6],
    output logic      [bfp_pkg::MAG_W-1:0] mag_o [6] = '{default: 20'h00000}
);
    // Fresh magnitudes appear only at the cycle tick, never in between.
    always @(posedge clk_sys_i) begin
        if (tick_i) begin
            mag_o <= set_i;
        end
    end
endmodule // bfp_front_model

//--- sim/bfp_top_sva.sv
// Port assertions for the breaker failure pick-up block.
`timescale 1ns/100ps
module bfp_top_sva #(
    parameter int CYCLE_CYCLES = 8
) (
    input wire logic clk_sys_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, force_allow_i,
    input wire logic start_o, retrip_o, breaker_failure_output_o, blocked_o, cycle_tick_o,
    input wire logic [2:0] status_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic [31:0] gap_q, gap_d;
    logic        seen_q, seen_d;
    // Cycles since the last tick; the first gap after reset is not judged.
    always_comb begin
        gap_d  = cycle_tick_o ? 32'h0 : gap_q + 32'h1;
        seen_d = seen_q | cycle_tick_o;
    end
    always_ff @(posedge clk_sys_i) begin
        gap_q  <= rst_i ? 32'h0 : gap_d;
        seen_q <= rst_i ? 1'b0 : seen_d;
    end
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    a_tick_period: assert property (cycle_tick_o && seen_q |-> gap_q == CYCLE_CYCLES - 1)
        else $error("tick spacing wrong");
    a_status_on_tick: assert property ($changed(status_o) && !force_allow_i
        && !$past(force_allow_i) |-> $past(cycle_tick_o)) else $error("status off tick");
    a_start_decode: assert property (start_o == (status_o inside {3'h1, 3'h2, 3'h3}))
        else $error("start decode wrong");
    a_blocked_quiet: assert property (blocked_o |-> status_o == 3'h4 && !retrip_o
        && !breaker_failure_output_o) else $error("blocked not quiet");
    a_retrip_state: assert property (retrip_o |-> status_o inside {3'h2, 3'h3})
        else $error("retrip outside status");
    a_fail_state: assert property (breaker_failure_output_o |-> status_o == 3'h3)
        else $error("failure outside status");
endmodule // bfp_top_sva
bind bfp_top bfp_top_sva #(.CYCLE_CYCLES(CYCLE_CYCLES)) u_sva (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .force_allow_i(force_allow_i), .start_o(start_o),
    .retrip_o(retrip_o), .breaker_failure_output_o(breaker_failure_output_o),
    .blocked_o(blocked_o), .cycle_tick_o(cycle_tick_o), .status_o(status_o));

//--- sim/bfp_top_test.sv
// Self-checking bench for the breaker failure pick-up block.
`timescale 1ns/100ps
module bfp_top_test;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00, relay = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic        ack, start, rt, fail, blk, tick, block = 1'b0, fallow = 1'b0;
    logic [2:0]  st;
    logic [15:0] sig = 16'h0000;
    logic [19:0] setv [6] = '{default: 20'h00000};
    logic [19:0] mag [6];
    logic [11:0] exp_t [4] = '{12'h0E4, 12'h0D2, 12'h000, 12'h4F6};
    int          miscompares = 0;
    int          comparisons = 0;
    // Short processing cycle keeps the run brief; all timing scales with it.
    bfp_top #(.CYCLE_CYCLES(8)) DUT (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .phase_l1_i(mag[0]), .phase_l2_i(mag[1]), .phase_l3_i(mag[2]),
        .residual_input_one_i(mag[3]), .residual_input_two_i(mag[4]),
        .computed_residual_i(mag[5]), .trip_sig_i(sig), .relay_ctrl_i(relay),
        .block_i(block), .force_allow_i(fallow), .start_o(start), .retrip_o(rt),
        .breaker_failure_output_o(fail), .blocked_o(blk), .status_o(st), .cycle_tick_o(tick));
    bfp_front_model FE (.clk_sys_i(clk_sys_i), .tick_i(tick), .set_i(setv), .mag_o(mag));
    always #2 clk_sys_i = ~clk_sys_i;
    // One classic cycle; the request holds until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_sys_i); while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // The extra edge lets the tick's own updates land before sampling.
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys_i iff tick === 1'b1);
        @(posedge clk_sys_i);
    endtask
    task automatic t_reset();
        rdchk(bfp_pkg::OFS_MODE, 32'h10);
        rdchk(bfp_pkg::OFS_PHASE, 32'h14);
        rdchk(bfp_pkg::OFS_RESID, 32'h4B0);
        rdchk(bfp_pkg::OFS_RT_DLY, 32'h14);
        rdchk(bfp_pkg::OFS_FL_DLY, 32'h28);
        rdchk(bfp_pkg::OFS_SRC, 32'h0);
        rdchk(bfp_pkg::OFS_FORCE, 32'h0);
        rdchk(8'hFC, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_phase();
        bus(1'b1, bfp_pkg::OFS_RT_DLY, 32'h2);
        bus(1'b1, bfp_pkg::OFS_FL_DLY, 32'h4);
        setv[1] <= 20'h000C9;
        ticks(4);
        chk({start, rt, fail, st}, 6'h21);
        ticks(1);
        chk({start, rt, fail, st}, 6'h32);
        ticks(1);
        chk({start, rt, fail, st}, 6'h32);
        ticks(1);
        chk({start, rt, fail, st}, 6'h3B);
        setv[1] <= 20'h000C2;
        ticks(4);
        rdchk(bfp_pkg::OFS_STATUS, 32'hBB);
        setv[1] <= 20'h000C1;
        ticks(4);
        chk({rt, fail, st}, 5'h00);
        $display("t_phase done");
    endtask
    task automatic t_resid();
        setv[3] <= 20'h004B1;
        setv[5] <= 20'h004B1;
        for (int s = 1; s < 4; s++) begin
            bus(1'b1, bfp_pkg::OFS_SRC, 32'(s));
            ticks(3);
            bus(1'b0, bfp_pkg::OFS_STATUS, 32'h0);
            chk(rd[6], s != 2);
        end
        bus(1'b1, bfp_pkg::OFS_SRC, 32'h0);
        ticks(2);
        bus(1'b0, bfp_pkg::OFS_STATUS, 32'h0);
        chk({rd[6], st}, 4'h0);
        setv[3] <= 20'h00000;
        setv[5] <= 20'h00000;
        $display("t_resid done");
    endtask
    task automatic t_masks();
        bus(1'b1, bfp_pkg::OFS_SIG_MASK, 32'h8);
        bus(1'b1, bfp_pkg::OFS_DO_MASK, 32'h1);
        for (int p = 0; p < 4; p++) begin
            sig   <= (p == 0 || p == 3) ? 16'h0008 : (p == 2) ? 16'h0004 : 16'h0000;
            relay <= {7'h00, p[0]};
            for (int m = 0; m < 12; m++) begin
                bus(1'b1, bfp_pkg::OFS_MODE, 32'h10 | m);
                ticks(2);
                bus(1'b0, bfp_pkg::OFS_STATUS, 32'h0);
                chk(rd[7], exp_t[p][m]);
            end
        end
        {sig, relay} <= 24'h000000;
        bus(1'b1, bfp_pkg::OFS_MODE, 32'h10);
        ticks(4);
        $display("t_masks done");
    endtask
    task automatic t_block_force();
        block   <= 1'b1;
        setv[0] <= 20'h000C9;
        ticks(4);
        chk({blk, st}, 4'hC);
        {block, setv[0]} <= 21'h000000;
        ticks(4);
        setv[0] <= 20'h000C9;
        ticks(4);
        block <= 1'b1;
        ticks(1);
        chk({start, blk, st}, 5'h0C);
        {block, setv[0]} <= 21'h000000;
        fallow <= 1'b1;
        for (int c = 0; c < 5; c++) begin
            bus(1'b1, bfp_pkg::OFS_FORCE, 32'(2 * c + 1));
            ticks(1);
            chk(st, c);
        end
        bus(1'b1, bfp_pkg::OFS_FORCE, 32'h0);
        fallow <= 1'b0;
        $display("t_block_force done");
    endtask
    task automatic t_noretrip();
        bus(1'b1, bfp_pkg::OFS_MODE, 32'h0);
        setv[2] <= 20'h000C9;
        ticks(12);
        chk({rt, fail}, 2'b01);
        $display("t_noretrip done");
    endtask
    task automatic stop_test();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence after a 16 cycle reset.
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_phase();
        t_resid();
        t_masks();
        t_block_force();
        t_noretrip();
        stop_test();
    end
    // Watchdog sized well beyond the expected run of about 1300 cycles.
    initial begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule // bfp_top_test
